// ===== include/pfcms_pkg.sv
// pfcms_pkg: shared constants and types of the conduction mode selector
// assumes a single 125 MHz clock and synchronous comparator inputs
package pfcms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_KHZ = 125000;

  ////////////////////////////////////////////////////////////////////////////
  // switching periods (cycle counts kept below 4096)
  localparam int unsigned CLAMP_FREQ_KHZ = 130;
  localparam int unsigned CONTINUOUS_MODE_FREQUENCY_KHZ = 65;
  localparam int unsigned CCM_ENTRY_PCT = 112;
  // least time, rounded up
  localparam int unsigned CLAMP_CYC = (CLK_KHZ + CLAMP_FREQ_KHZ - 1) / CLAMP_FREQ_KHZ;
  // switching period, rounded down
  localparam int unsigned CONTINUOUS_MODE_PERIOD_CYC = CLK_KHZ / CONTINUOUS_MODE_FREQUENCY_KHZ;
  localparam int unsigned CCM_ENTRY_CYC = CONTINUOUS_MODE_PERIOD_CYC * CCM_ENTRY_PCT / 100;
  localparam int unsigned CYC_W = 12;
  localparam int unsigned RUN_LEN = 8;
  localparam int unsigned RUN_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // long timers in their own units; cycle counts are top parameters
  localparam int unsigned CONTINUOUS_EXIT_BLANKING_TIME_MS = 360;
  localparam int unsigned BROWNOUT_BLANKING_TIME_MS = 650;
  localparam int unsigned HIGH_TO_LOW_LINE_TIMER_US = 26000;
  localparam int unsigned LOW_TO_HIGH_LINE_FILTER_US = 360;
  localparam int unsigned LINE_LOCKOUT_MS = 515;
  localparam int unsigned UNDERVOLTAGE_RECOVERY_DELAY_MS = 515;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    MODE_CRM = 2'h0,
    MODE_DCM = 2'h1,
    MODE_CCM = 2'h2
  } pfcms_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ON    = 2'h1,
    ST_DEMAG = 2'h2,
    ST_WAIT  = 2'h3
  } pfcms_state_t;

  typedef struct packed {
    logic on_end;       // on-time ended by the current loop
    logic demag_done;   // inductor current reached zero
    logic valley;       // drain voltage valley detected
    logic cur_entry;    // current above continuous_entry_current_ref
    logic cur_hold;     // current above continuous_hold_current_ref
  } pfcms_sense_t;

  typedef struct packed {
    logic bo_low;       // line below brown-out lower threshold
    logic line_low;     // line below low-line threshold
    logic line_high;    // line above high-line threshold
    logic buv_low;      // bulk_undervoltage_fault comparator
  } pfcms_line_t;

  typedef struct packed {
    pfcms_mode_t mode;
    logic        brownout;
    logic        high_line;
    logic        buv_wait;
    logic        lockout;
  } pfcms_stat_t;

endpackage

// ===== hdl/pfcms_persist.sv
// pfcms_persist: a level must hold for COUNT cycles before done rises
// assumes cond_in is synchronous; a drop of cond_in restarts the count
`timescale 1ns/1ns
module pfcms_persist #(
  parameter int unsigned COUNT = 4
) (
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  input  wire logic cond_in,
  output logic      done_out
);

  localparam int unsigned W = $clog2(COUNT + 1);

  logic [W-1:0] cnt_q;
  wire          full = (cnt_q == W'(COUNT));

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else if (!cond_in) begin
      cnt_q <= '0;
    end else if (!full) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done_out = full;

  property p_persist_drop;
    @(posedge clock_in) disable iff (!rst_b_in)
      !cond_in |=> !done_out;
  endproperty
  a_persist_drop: assert property (p_persist_drop) // see R10
    else $error("persist done without held condition");

endmodule // pfcms_persist

// ===== hdl/pfcms_cycle_meter.sv
// pfcms_cycle_meter: times one current cycle from its start strobe
// assumes start_in is a one-cycle pulse at each on-time start
`timescale 1ns/1ns
module pfcms_cycle_meter #(
  parameter int unsigned W = 12
) (
  input  wire logic         clock_in,
  input  wire logic         rst_b_in,
  input  wire logic         start_in,
  input  wire logic         cur_above_in,
  output logic [W-1:0]      cnt_out,
  output logic              cur_seen_out
);

  logic [W-1:0] cnt_q;
  logic         seen_q;
  wire          sat = &cnt_q;

  // saturation keeps a stuck cycle reading as long rather than wrapping short
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      cnt_q  <= start_in ? '0 : (sat ? cnt_q : cnt_q + 1'b1); // see R13
      seen_q <= start_in ? cur_above_in : (seen_q | cur_above_in); // see R14
    end
  end

  assign cnt_out      = cnt_q;
  assign cur_seen_out = seen_q;

  property p_meter_restart;
    @(posedge clock_in) disable iff (!rst_b_in)
      start_in |=> (cnt_out == '0);
  endproperty
  a_meter_restart: assert property (p_meter_restart) // see R13
    else $error("cycle meter did not restart");

endmodule // pfcms_cycle_meter

// ===== hdl/pfcms_mode_sel.sv
// pfcms_mode_sel: conduction mode selector and line supervisors
// assumes analog comparators present synchronous levels in sense_in/line_in
//
// Function
// R1 - short cycle waits out clamp period (DCM)
// R2 - cycle between clamp and 112% is CrM
// R3 - eight long qualified cycles enter continuous mode
// R4 - continuous mode switches at fixed period
// R5 - leave continuous mode after blanking without runs
// R6 - CrM/DCM chosen every cycle, switching continues
// R7 - DCM turn-on waits for a valley
// R8 - brown-out after 650 ms low line sense
// R9 - high-to-low range after 26 ms low
// R10 - low-to-high indication filtered 360 us
// R11 - 515 ms lockout after range change
// R12 - resume 515 ms after bulk undervoltage
// R13 - cycle is on-time plus demagnetization
// R14 - long cycle needs current above reference
// R15 - failed cycle clears the run counter
`timescale 1ns/1ns
module pfcms_mode_sel
  import pfcms_pkg::*;
#(
  parameter int unsigned CCM_BLANK_CYC  = CONTINUOUS_EXIT_BLANKING_TIME_MS * CLK_KHZ,
  parameter int unsigned BO_BLANK_CYC   = BROWNOUT_BLANKING_TIME_MS * CLK_KHZ,
  parameter int unsigned HI_LO_CYC      = HIGH_TO_LOW_LINE_TIMER_US * CLK_MHZ,
  parameter int unsigned LO_HI_CYC      = LOW_TO_HIGH_LINE_FILTER_US * CLK_MHZ,
  parameter int unsigned LOCKOUT_CYC    = LINE_LOCKOUT_MS * CLK_KHZ,
  parameter int unsigned BUV_RECOV_CYC  = UNDERVOLTAGE_RECOVERY_DELAY_MS * CLK_KHZ
) (
  input  wire logic          clock_in,
  input  wire logic          rst_b_in,
  input  wire pfcms_sense_t  sense_in,
  input  wire pfcms_line_t   line_in,
  output logic               drv_out,
  output pfcms_stat_t        stat_out
);

  localparam int unsigned BLANK_W = $clog2(CCM_BLANK_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // line supervisors
  logic brownout;
  logic buv_ok;
  logic hi_lo_done;
  logic lo_hi_done;
  logic lockout_done;
  logic high_line_q;
  logic range_chg_q;

  pfcms_persist #(.COUNT(BO_BLANK_CYC)) u_bo (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .cond_in  (line_in.bo_low),
    .done_out (brownout)             // see R8
  );

  // delay counts from the moment the bulk comparator releases
  pfcms_persist #(.COUNT(BUV_RECOV_CYC)) u_buv (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .cond_in  (!line_in.buv_low),
    .done_out (buv_ok)               // see R12
  );

  pfcms_persist #(.COUNT(HI_LO_CYC)) u_hilo (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .cond_in  (line_in.line_low && high_line_q),
    .done_out (hi_lo_done)           // see R9
  );

  pfcms_persist #(.COUNT(LO_HI_CYC)) u_lohi (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .cond_in  (line_in.line_high && !high_line_q),
    .done_out (lo_hi_done)           // see R10
  );

  // also runs from reset, so the first upward change waits out the lockout
  pfcms_persist #(.COUNT(LOCKOUT_CYC)) u_lock (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .cond_in  (!range_chg_q),
    .done_out (lockout_done)         // see R11
  );

  wire go_low  = high_line_q && hi_lo_done;
  wire go_high = !high_line_q && lo_hi_done && lockout_done; // see R11

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      high_line_q <= 1'b0;
      range_chg_q <= 1'b0;
    end else begin
      high_line_q <= go_high ? 1'b1 : (go_low ? 1'b0 : high_line_q);
      range_chg_q <= go_high || go_low;
    end
  end

  wire run_ok = !brownout && buv_ok && !line_in.buv_low;

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  pfcms_state_t    state_q;
  pfcms_state_t    state_d;
  logic            ccm_q;
  logic            dcm_q;
  logic [CYC_W-1:0] cnt;
  logic            cur_seen;

  wire clamp_done = cnt >= CYC_W'(CLAMP_CYC - 1);
  wire per_done   = cnt >= CYC_W'(CONTINUOUS_MODE_PERIOD_CYC - 1);

  // on-time then demagnetization form the measured cycle
  wire cyc_end  = (state_q == ST_DEMAG) && (sense_in.demag_done || (ccm_q && per_done)); // see R13
  wire cut      = (state_q == ST_DEMAG) && !sense_in.demag_done && ccm_q && per_done;
  wire wait_go  = ccm_q ? per_done                          // see R4
                        : (clamp_done && (!dcm_q || sense_in.valley)); // see R1 // see R7
  wire start    = run_ok && ((state_q == ST_IDLE) || (state_q == ST_WAIT && wait_go) || cut);
  wire is_short = cnt < CYC_W'(CLAMP_CYC);

  always_comb begin
    state_d = state_q;
    if (!run_ok) begin
      state_d = ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  state_d = ST_ON;
        ST_ON:    state_d = sense_in.on_end ? ST_DEMAG : ST_ON;
        ST_DEMAG: state_d = cut ? ST_ON : (cyc_end ? ST_WAIT : ST_DEMAG);
        ST_WAIT:  state_d = wait_go ? ST_ON : ST_WAIT;
        default:  state_d = ST_IDLE;
      endcase
    end
  end

  // a DCM/CrM decision per cycle, never a stop in switching
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      dcm_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cyc_end) begin
        dcm_q <= !ccm_q && is_short; // see R1 // see R2 // see R6
      end
    end
  end

  pfcms_cycle_meter #(.W(CYC_W)) u_meter (
    .clock_in     (clock_in),
    .rst_b_in     (rst_b_in),
    .start_in     (start),
    .cur_above_in (ccm_q ? sense_in.cur_hold : sense_in.cur_entry), // see R14
    .cnt_out      (cnt),
    .cur_seen_out (cur_seen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // continuous mode entry and exit
  logic [RUN_W-1:0]   run_q;
  logic [BLANK_W-1:0] blank_q;

  wire long_entry = cnt > CYC_W'(CCM_ENTRY_CYC);
  wire long_hold  = cut || (cnt > CYC_W'(CONTINUOUS_MODE_PERIOD_CYC));
  wire qual       = cur_seen && (ccm_q ? long_hold : long_entry); // see R14
  wire hit8       = cyc_end && qual && (run_q == RUN_W'(RUN_LEN - 1));
  wire blank_end  = blank_q == BLANK_W'(CCM_BLANK_CYC - 1);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_q <= '0;
    end else if (cyc_end) begin
      run_q <= (qual && !hit8) ? run_q + 1'b1 : '0; // see R15 // see R3
    end
  end

  // only a whole fresh run restarts the blanking, so light load drops out
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ccm_q   <= 1'b0;
      blank_q <= '0;
    end else if (!run_ok) begin
      ccm_q   <= 1'b0;
      blank_q <= '0;
    end else if (hit8) begin
      ccm_q   <= 1'b1;                 // see R3
      blank_q <= '0;
    end else if (ccm_q) begin
      ccm_q   <= !blank_end;           // see R5 // see R4
      blank_q <= blank_end ? '0 : blank_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign drv_out            = (state_q == ST_ON);
  assign stat_out.mode      = ccm_q ? MODE_CCM : (dcm_q ? MODE_DCM : MODE_CRM);
  assign stat_out.brownout  = brownout;
  assign stat_out.high_line = high_line_q;
  assign stat_out.buv_wait  = !buv_ok;
  assign stat_out.lockout   = !lockout_done;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_run8;
    cyc_end && qual && (run_q == RUN_W'(RUN_LEN - 1));
  endsequence

  property p_clamp;
    @(posedge clock_in) disable iff (!rst_b_in)
      (state_q == ST_WAIT && !ccm_q && !clamp_done) |-> !start;
  endproperty
  a_clamp: assert property (p_clamp) // see R1
    else $error("cycle started inside clamp period");

  property p_crm;
    @(posedge clock_in) disable iff (!rst_b_in)
      (cyc_end && !ccm_q && !is_short && !hit8) |=> (stat_out.mode == MODE_CRM);
  endproperty
  a_crm: assert property (p_crm) // see R2
    else $error("long cycle not in critical mode");

  property p_enter;
    @(posedge clock_in) disable iff (!rst_b_in)
      $rose(ccm_q) |-> $past(hit8) && $past(run_q) == RUN_W'(RUN_LEN - 1);
  endproperty
  a_enter: assert property (p_enter) // see R3
    else $error("continuous mode entered without run of eight");

  property p_run_enter;
    @(posedge clock_in) disable iff (!rst_b_in)
      (s_run8 and run_ok) |=> ccm_q;
  endproperty
  a_run_enter: assert property (p_run_enter) // see R3
    else $error("run of eight ignored");

  property p_fixed;
    @(posedge clock_in) disable iff (!rst_b_in)
      (ccm_q && run_ok && state_q == ST_WAIT && per_done) |=> drv_out;
  endproperty
  a_fixed: assert property (p_fixed) // see R4
    else $error("continuous mode missed its period");

  property p_exit;
    @(posedge clock_in) disable iff (!rst_b_in)
      $fell(ccm_q) |-> $past(blank_end) || !$past(run_ok);
  endproperty
  a_exit: assert property (p_exit) // see R5
    else $error("continuous mode left before blanking end");

  property p_dcm_keeps;
    @(posedge clock_in) disable iff (!rst_b_in)
      (cyc_end && !ccm_q && is_short && run_ok) |=> dcm_q && state_q == ST_WAIT;
  endproperty
  a_dcm_keeps: assert property (p_dcm_keeps) // see R6
    else $error("short cycle not held in discontinuous wait");

  property p_valley;
    @(posedge clock_in) disable iff (!rst_b_in)
      (state_q == ST_WAIT && dcm_q && !ccm_q && start) |-> sense_in.valley;
  endproperty
  a_valley: assert property (p_valley) // see R7
    else $error("discontinuous turn-on off valley");

  property p_run_clear;
    @(posedge clock_in) disable iff (!rst_b_in)
      (cyc_end && !qual) |=> (run_q == '0);
  endproperty
  a_run_clear: assert property (p_run_clear) // see R15
    else $error("run counter kept after failed cycle");

  property p_stop;
    @(posedge clock_in) disable iff (!rst_b_in)
      (brownout || line_in.buv_low) |=> !drv_out;
  endproperty
  a_stop: assert property (p_stop) // see R12
    else $error("switching while stopped");

endmodule // pfcms_mode_sel

// ===== dv/pfcms_stage_model.sv
// pfcms_stage_model: behavioural power stage and sense comparators
// assumes drv_in is the gate drive; on and demag times are clock cycles
`timescale 1ns/1ns
module pfcms_stage_model
  import pfcms_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        drv_in,
  input  wire logic [11:0] on_cyc_in,
  input  wire logic [11:0] dem_cyc_in,
  input  wire logic        entry_in,
  input  wire logic        hold_in,
  output pfcms_sense_t     sense_out
);
  logic [11:0] on_q;
  logic [11:0] dem_q;

  ////////////////////////////////////////////////////////////////////////////
  // demag starts when the gate drops; a new on-time cuts it short
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      on_q  <= 12'h000;
      dem_q <= 12'h000;
    end else if (drv_in) begin
      on_q  <= on_q + 12'h001;
      dem_q <= 12'h000;
    end else begin
      on_q  <= 12'h000;
      if (dem_q != 12'hFFF) dem_q <= dem_q + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ringing gives a valley every 16 cycles once the inductor is empty
  assign sense_out.on_end     = drv_in && (on_q >= on_cyc_in);
  assign sense_out.demag_done = !drv_in && (dem_q >= dem_cyc_in);
  assign sense_out.valley     = sense_out.demag_done && (dem_q[3:0] == 4'h0);
  assign sense_out.cur_entry  = drv_in & entry_in;
  assign sense_out.cur_hold   = drv_in & hold_in;
endmodule // pfcms_stage_model

// ===== dv/tb_top.sv
// tb_top: self-checking bench of the conduction mode selector
// assumes shortened timers; inputs change on the falling clock edge
`timescale 1ns/1ns
module tb_top;
  import pfcms_pkg::*;
  typedef struct {
    int on, dm, en, ho, n;
    pfcms_mode_t md;
    int lo, hi;
  } pfcms_row_t;

  // shortened timers, so a whole run stays well inside the cycle budget
  localparam int unsigned BLANK_TB = 12000;
  localparam int unsigned BO_TB    = 200;
  localparam int unsigned HILO_TB  = 100;
  localparam int unsigned LOHI_TB  = 20;
  localparam int unsigned LOCK_TB  = 300;
  localparam int unsigned BUV_TB   = 50;

  logic         clock_in;
  logic         rst_b_in;
  pfcms_sense_t sense;
  pfcms_line_t  line;
  logic         drv_out;
  pfcms_stat_t  stat_out;
  logic [11:0]  on_c;
  logic [11:0]  dm_c;
  logic         en_c;
  logic         ho_c;
  int           n_fail;
  int           checks_done;
  int           per;
  logic         hi_seen;

  ////////////////////////////////////////////////////////////////////////////
  // short cycles give DCM outside CCM, middle CrM, long ones build the run of 8
  pfcms_row_t rows [9] = '{
    '{200, 200, 1, 1, 3, MODE_DCM, 962, 982},
    '{600, 600, 1, 1, 3, MODE_CRM, 1200, 1215},
    '{200, 200, 1, 1, 2, MODE_DCM, 962, 982},
    '{1300, 900, 1, 0, 7, MODE_CRM, 2200, 2215},
    '{1300, 900, 0, 1, 1, MODE_CRM, 2200, 2215},
    '{1300, 900, 1, 1, 7, MODE_CRM, 2200, 2215},
    '{1300, 900, 1, 1, 1, MODE_CCM, 2200, 2215},
    '{1300, 900, 1, 1, 3, MODE_CCM, 1921, 1925},
    '{200, 200, 1, 1, 2, MODE_CCM, 1921, 1925}
  };

  pfcms_mode_sel #(
    .CCM_BLANK_CYC (BLANK_TB),
    .BO_BLANK_CYC  (BO_TB),
    .HI_LO_CYC     (HILO_TB),
    .LO_HI_CYC     (LOHI_TB),
    .LOCKOUT_CYC   (LOCK_TB),
    .BUV_RECOV_CYC (BUV_TB)
  ) DUT (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .sense_in (sense),
    .line_in  (line),
    .drv_out  (drv_out),
    .stat_out (stat_out)
  );

  pfcms_stage_model stage (
    .clock_in   (clock_in),
    .rst_b_in   (rst_b_in),
    .drv_in     (drv_out),
    .on_cyc_in  (on_c),
    .dem_cyc_in (dm_c),
    .entry_in   (en_c),
    .hold_in    (ho_c),
    .sense_out  (sense)
  );

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic miss(string msg);
    n_fail++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  task automatic chk_bit(logic got, logic exp);
    checks_done++;
    if (got !== exp) miss("status bit");
  endtask

  task automatic chk_mode(pfcms_mode_t got, pfcms_mode_t exp);
    checks_done++;
    if (got !== exp) miss("mode");
  endtask

  task automatic chk_per(int got, int lo, int hi);
    checks_done++;
    if (got < lo || got > hi) miss("switching period");
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge clock_in);
  endtask

  // bounded wait for the next gate turn-on; per counts cycles since the last
  task automatic wait_rise();
    logic low;
    low = 1'b0;
    per = 0;
    for (int k = 0; k < 5000; k++) begin
      @(negedge clock_in);
      per++;
      if (drv_out !== 1'b1) low = 1'b1;
      else if (low) return;
    end
    miss("gate drive stalled");
    complete_run();
  endtask

  // the gate must stay off through the first 45 cycles of the 50-cycle recovery delay
  task automatic buv_quiet();
    hi_seen = 1'b0;
    for (int k = 0; k < 45; k++) begin
      @(negedge clock_in);
      if (drv_out !== 1'b0) hi_seen = 1'b1;
    end
    chk_bit(hi_seen, 1'b0);
    chk_bit(stat_out.buv_wait, 1'b1);
    wait_rise();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    checks_done = 0;
    rst_b_in = 1'b0;
    line = '{bo_low: 1'b0, line_low: 1'b0, line_high: 1'b1, buv_low: 1'b0};
    {on_c, dm_c, en_c, ho_c} = {12'h0C8, 12'h0C8, 1'b1, 1'b1};
    idle(8);
    chk_bit(drv_out, 1'b0);
    chk_mode(stat_out.mode, MODE_CRM);
    chk_bit(stat_out.lockout, 1'b1);
    chk_bit(stat_out.high_line, 1'b0);
    rst_b_in = 1'b1;
    buv_quiet();
    idle(200);
    chk_bit(stat_out.high_line, 1'b0);
    idle(90);
    chk_bit(stat_out.high_line, 1'b1);
    wait_rise();
    foreach (rows[i]) begin
      on_c = 12'(rows[i].on);
      dm_c = 12'(rows[i].dm);
      en_c = rows[i].en[0];
      ho_c = rows[i].ho[0];
      repeat (rows[i].n) wait_rise();
      chk_mode(stat_out.mode, rows[i].md);
      chk_per(per, rows[i].lo, rows[i].hi);
    end
    // short cycles keep CCM only until the blanking runs out
    for (int k = 0; k < 16000 && stat_out.mode === MODE_CCM; k++) idle(1);
    // the first cycle after the exit may still carry the continuous-mode decision
    wait_rise();
    wait_rise();
    chk_mode(stat_out.mode, MODE_DCM);
    chk_per(per, 962, 982);
    line.bo_low = 1'b1;
    idle(190);
    chk_bit(stat_out.brownout, 1'b0);
    idle(20);
    chk_bit(stat_out.brownout, 1'b1);
    chk_bit(drv_out, 1'b0);
    line.bo_low = 1'b0;
    wait_rise();
    line.buv_low = 1'b1;
    idle(20);
    chk_bit(drv_out, 1'b0);
    line.buv_low = 1'b0;
    buv_quiet();
    line = '{bo_low: 1'b0, line_low: 1'b1, line_high: 1'b0, buv_low: 1'b0};
    idle(90);
    chk_bit(stat_out.high_line, 1'b1);
    idle(25);
    chk_bit(stat_out.high_line, 1'b0);
    line = '{bo_low: 1'b0, line_low: 1'b0, line_high: 1'b1, buv_low: 1'b0};
    idle(150);
    chk_bit(stat_out.lockout, 1'b1);
    chk_bit(stat_out.high_line, 1'b0);
    idle(130);
    chk_bit(stat_out.high_line, 1'b0);
    idle(15);
    chk_bit(stat_out.high_line, 1'b1);
    complete_run();
  end
endmodule // tb_top
